// ### rtl/cfg_pkg.sv
/*
 constants, enums and carrier structs shared by the configuration
 decode block and its two helper modules.
 assumes a single core clock domain.
*/
package cfg_pkg;
   // dword offsets inside the legacy space, its top bound and the pointer off values
   localparam logic [9:0]  HDR_TYPE_DW   = 10'h003;
   localparam logic [9:0]  ROM_BAR_DW    = 10'h00c;
   localparam logic [9:0]  INT_PIN_DW    = 10'h00f;
   localparam logic [9:0]  LEGACY_TOP_DW = 10'h040;
   localparam logic [5:0]  LEGACY_OFF    = 6'h3f;
   localparam logic [9:0]  EXT_OFF       = 10'h3ff;
   // serial-number capability
   localparam logic [11:0] SN_BASE       = 12'h100;
   localparam logic [15:0] SN_ID         = 16'h0003;
   localparam logic [3:0]  SN_VERSION    = 4'h1;
   localparam logic [11:0] SN_NEXT_NONE  = 12'h000;
   localparam logic [11:0] SN_NEXT_A     = 12'h10c;
   localparam logic [11:0] SN_NEXT_B     = 12'h128;
   localparam logic [9:0]  LAST_DW_RST   = 10'h040;
   // field positions, default values and counts
   localparam int          TD_BIT        = 15;
   localparam int          ROM_MASK_LSB  = 11;
   localparam logic [31:0] ROM_NONE      = 32'h0000_0000;
   localparam logic [1:0]  ASPM_L0S      = 2'h1;
   localparam int          MSG_KINDS     = 11;
   localparam int          IDLE_STATES   = 5;

   typedef enum logic [3:0] {
      MSG_ERR_COR = 4'h0, MSG_ERR_NONFATAL = 4'h1, MSG_ERR_FATAL = 4'h2,
      MSG_INTA = 4'h3, MSG_INTB = 4'h4, MSG_INTC = 4'h5, MSG_INTD = 4'h6,
      MSG_PM_PME = 4'h7, MSG_PME_TO_ACK = 4'h8, MSG_UNLOCK = 4'h9,
      MSG_PME_TURN_OFF = 4'ha
   } msg_kind_e;

   // index equals the bit in the inferred-idle state mask
   typedef enum logic [2:0] {
      LT_L0 = 3'h0, LT_RCV_CFG = 3'h1, LT_SPEED_OK = 3'h2,
      LT_SPEED_FAIL = 3'h3, LT_LOOPBACK = 3'h4, LT_OTHER = 3'h7
   } ltssm_e;

   typedef struct packed {
      logic valid; logic write; logic [9:0] dword; logic [31:0] wdata;
   } cfg_req_s;
   typedef struct packed {
      logic valid; logic to_user; logic ur; logic [31:0] rdata;
   } cfg_rsp_s;
   typedef struct packed {
      logic valid; logic sop; logic eop; logic is_msg;
      msg_kind_e kind; logic [31:0] data;
   } rx_beat_s;
   typedef struct packed {
      logic [1:0] aspm; logic [2:0] l0s_exit; logic clk_pm;
      logic dll_active;
   } link_cap_s;
endpackage : cfg_pkg

// ### rtl/idle_recovery.sv
/*
 inferred electrical idle gating and L0 to Recovery entry.
 assumes analog idle arrives from a pin; the rest is core-clock logic.
*/
`timescale 1ns/1ps
`default_nettype none
module idle_recovery (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // static settings
   input  wire logic [4:0]        idle_mask,
   input  wire logic              recovery_on_idle_from_l0,
   // physical layer
   input  wire cfg_pkg::ltssm_e   ltssm,
   input  wire logic              inferred_idle,
   input  wire logic              analog_idle_pin,
   input  wire logic              eios_seen,
   // results
   output logic                   infer_active,
   output logic                   enter_recovery
);
   import cfg_pkg::*;
   logic sync1_r, sync2_r, infer_nxt, enter_nxt, idle_hit;

   always_comb begin
      infer_nxt = (ltssm != LT_OTHER) && idle_mask[ltssm];
      idle_hit  = idle_mask[0] ? inferred_idle : (sync2_r && !eios_seen);
      enter_nxt = recovery_on_idle_from_l0 && (ltssm == LT_L0) && idle_hit;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync1_r        <= 1'b0;
         sync2_r        <= 1'b0;
         infer_active   <= 1'b0;
         enter_recovery <= 1'b0;
      end else begin
         sync1_r        <= analog_idle_pin;
         sync2_r        <= sync1_r;
         infer_active   <= infer_nxt;
         enter_recovery <= enter_nxt;
      end
   end
endmodule : idle_recovery
`default_nettype wire

// ### rtl/msg_router.sv
/*
 receive path: message decode, mask-gated forwarding to user logic and
 optional digest trim (TD cleared, ECRC dword removed).
 assumes beats arrive with no back-pressure, one per cycle at most.
*/
`timescale 1ns/1ps
`default_nettype none
module msg_router (
   // clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // static settings
   input  wire logic [10:0]             message_route_mask,
   input  wire logic                    rx_digest_trim,
   // receive in and out
   input  wire cfg_pkg::rx_beat_s       rx_in,
   output cfg_pkg::rx_beat_s            rx_out,
   // decoder side
   output logic                         msg_decoded,
   output cfg_pkg::msg_kind_e           msg_decoded_kind
);
   import cfg_pkg::*;
   rx_beat_s hold_r, hold_nxt, out_nxt, beat;
   logic     hold_v_r, hold_v_nxt, td_r, td_nxt, drop_r, drop_nxt;
   logic     trim_tlp, drop_now;

   always_comb begin
      beat       = rx_in;
      td_nxt     = td_r;
      drop_nxt   = drop_r;
      if (rx_in.valid && rx_in.sop) begin
         td_nxt   = rx_in.data[TD_BIT];
         drop_nxt = rx_in.is_msg && !message_route_mask[rx_in.kind];
         if (rx_digest_trim)
            beat.data[TD_BIT] = 1'b0;
      end
      trim_tlp   = rx_digest_trim && td_nxt;
      drop_now   = drop_nxt;
      out_nxt    = '0;
      hold_nxt   = hold_r;
      hold_v_nxt = hold_v_r;
      if (rx_in.valid) begin
         if (!trim_tlp) begin
            out_nxt = beat;
         end else if (rx_in.eop) begin
            out_nxt     = hold_r;
            out_nxt.eop = 1'b1;
            out_nxt.valid = hold_v_r;
            hold_v_nxt  = 1'b0;
         end else begin
            out_nxt    = hold_v_r ? hold_r : '0;
            hold_nxt   = beat;
            hold_v_nxt = 1'b1;
         end
         if (drop_now)
            out_nxt.valid = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hold_r           <= '0;
         hold_v_r         <= 1'b0;
         td_r             <= 1'b0;
         drop_r           <= 1'b0;
         rx_out           <= '0;
         msg_decoded      <= 1'b0;
         msg_decoded_kind <= MSG_ERR_COR;
      end else begin
         hold_r           <= hold_nxt;
         hold_v_r         <= hold_v_nxt;
         td_r             <= td_nxt;
         drop_r           <= drop_nxt;
         rx_out           <= out_nxt;
         msg_decoded      <= rx_in.valid && rx_in.sop && rx_in.is_msg;
         msg_decoded_kind <= rx_in.kind;
      end
   end
endmodule : msg_router
`default_nettype wire

// ### rtl/cfg_space_decode.sv
/*
 configuration request decode for a PCI Express port: routes legacy and
 extended requests to user logic or the internal config manager,
 answers Unsupported Request for unimplemented dwords, serves the
 header type, expansion ROM BAR, interrupt pin and serial-number
 capability, and drives the static link capability fields. instantiates
 the receive message router and the idle recovery helper.
 assumes one core clock; static settings are module parameters.
*/
// Functional notes
// - serial-number capability decoded relative to a 12-bit byte base, 100h.
// - capability header reports identifier 0003h and version 1h.
// - next pointer is 000h when last, else 10Ch or 128h.
// - absent serial-number capability is unreachable from link and management port.
// - messages always decoded; forwarded to user only when mask bit set.
// - mask bits: errors, INTA-INTD, PM_PME, PME_TO_ACK, Unlock, PME_Turn_Off.
// - digest trim clears TD and removes ECRC before delivery.
// - leave L0 for Recovery on inferred or analog idle without EIOS.
// - ROM BAR: bit0 implement, [10:1] zero, [31:11] aperture mask.
// - legacy requests at or above 6-bit pointer go to user; 3Fh none.
// - extended requests at or above 10-bit pointer go user; 3FFh disables.
// - header type only 00h or 01h; bit7 zero, bit0 selects type.
// - inferred idle applied in LTSSM states selected by 5-bit mask.
// - interrupt pin 0 means none, 1 to 4 means INTA to INTD.
// - internal accesses above last implemented dword get Unsupported Request.
// - no extended capabilities: limit 0x40, offset 0x100 reads zero.
// - gap between last dword and extended pointer answers Unsupported Request.
// - root port advertises configured link number in TS1/TS2; endpoints 00h.
// - active PM support field only takes value 1.
// - L0s exit latency code 0 to 7, doubling per step.
// - clock removal and link active reporting bits; endpoints leave reporting off.
`timescale 1ns/1ps
`default_nettype none
module cfg_space_decode #(
   parameter logic        ROOT_PORT                = 1'b0,
   parameter logic [7:0]  LINK_NUMBER              = 8'h00,
   parameter logic [11:0] SERIAL_NUMBER_CAP_BASE   = cfg_pkg::SN_BASE,
   parameter logic [11:0] SERIAL_NUMBER_NEXT_PTR   = cfg_pkg::SN_NEXT_NONE,
   parameter logic        SERIAL_NUMBER_PRESENT    = 1'b1,
   // arbitrary serial number value
   parameter logic [63:0] SERIAL_NUMBER_VALUE      = 64'h0000_0000_0000_0001,
   parameter logic [10:0] MESSAGE_ROUTE_MASK       = 11'h000,
   parameter logic        RX_DIGEST_TRIM           = 1'b0,
   parameter logic        RECOVERY_ON_IDLE_FROM_L0 = 1'b1,
   parameter logic [4:0]  INFERRED_IDLE_MASK       = 5'h00,
   parameter logic [31:0] EXPANSION_ROM            = cfg_pkg::ROM_NONE,
   parameter logic [5:0]  LEGACY_USER_CFG_POINTER  = cfg_pkg::LEGACY_OFF,
   parameter logic [9:0]  EXTENDED_USER_CFG_POINTER= cfg_pkg::EXT_OFF,
   parameter logic [7:0]  HEADER_TYPE              = 8'h00,
   parameter logic [7:0]  INTERRUPT_PIN            = 8'h01,
   parameter logic [9:0]  LAST_IMPLEMENTED_DWORD   = cfg_pkg::LAST_DW_RST,
   parameter logic [1:0]  ACTIVE_PM_SUPPORT_FIELD  = cfg_pkg::ASPM_L0S,
   parameter logic [2:0]  L0S_EXIT_COMCLK_GEN1     = 3'h0,
   parameter logic        CLOCK_PM_SUPPORT         = 1'b0,
   parameter logic        LINK_ACTIVE_REPORTING    = 1'b0
) (
   // clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // configuration requests from link or management port
   input  wire cfg_pkg::cfg_req_s       cfg_req,
   output cfg_pkg::cfg_rsp_s            cfg_rsp,
   // received TLP stream
   input  wire cfg_pkg::rx_beat_s       rx_in,
   output cfg_pkg::rx_beat_s            rx_user,
   output logic                         msg_decoded,
   output cfg_pkg::msg_kind_e           msg_decoded_kind,
   // physical layer
   input  wire cfg_pkg::ltssm_e         ltssm,
   input  wire logic                    inferred_idle,
   input  wire logic                    analog_idle_pin,
   input  wire logic                    eios_seen,
   output logic                         infer_active,
   output logic                         enter_recovery,
   // static status toward the rest of the port
   output logic [7:0]                   advertised_link_number,
   output cfg_pkg::link_cap_s           link_caps,
   output logic [31:0]                  rom_bar,
   output logic                         legacy_intx_used,
   output logic [1:0]                   legacy_intx_line,
   output logic                         settings_bad
);
   import cfg_pkg::*;

   // settings forced to legal values; unsupported inputs fall back, save the serial-number base and recovery enable (BAD only)
   localparam logic [7:0]  HDR_OK =
      (HEADER_TYPE == 8'h01 && ROOT_PORT) ? 8'h01 : 8'h00;
   localparam logic [11:0] NEXT_OK =
      (SERIAL_NUMBER_NEXT_PTR == SN_NEXT_A ||
       SERIAL_NUMBER_NEXT_PTR == SN_NEXT_B) ?
      SERIAL_NUMBER_NEXT_PTR : SN_NEXT_NONE;
   localparam logic [7:0]  PIN_OK =
      (INTERRUPT_PIN <= 8'h04) ? INTERRUPT_PIN : 8'h00;
   localparam logic [31:0] ROM_MASK =
      EXPANSION_ROM[0] ? {EXPANSION_ROM[31:ROM_MASK_LSB], 10'h000, 1'b1}
                       : ROM_NONE;
   localparam logic [9:0]  SN_DW = SERIAL_NUMBER_CAP_BASE[11:2];
   localparam logic        BAD =
      (SERIAL_NUMBER_CAP_BASE != SN_BASE) ||
      (HEADER_TYPE != HDR_OK) ||
      (SERIAL_NUMBER_NEXT_PTR != NEXT_OK) ||
      (INTERRUPT_PIN != PIN_OK) ||
      (ACTIVE_PM_SUPPORT_FIELD != ASPM_L0S) ||
      (!ROOT_PORT && (LINK_NUMBER != 8'h00)) ||
      (!ROOT_PORT && LINK_ACTIVE_REPORTING) ||
      !RECOVERY_ON_IDLE_FROM_L0 ||
      (EXPANSION_ROM[10:1] != 10'h000);

   // request decode state
   cfg_rsp_s    rsp_nxt;
   logic [31:0] rom_r, rom_nxt;
   logic        legacy_req, user_legacy, user_ext, to_user;
   logic        above_last, sn_hit;
   logic [1:0]  sn_idx;
   logic [9:0]  sn_off;
   logic [31:0] rd_word;

   always_comb begin
      legacy_req  = cfg_req.dword < LEGACY_TOP_DW;
      user_legacy = legacy_req &&
                    (LEGACY_USER_CFG_POINTER != LEGACY_OFF) &&
                    (cfg_req.dword[5:0] >= LEGACY_USER_CFG_POINTER);
      user_ext    = !legacy_req &&
                    (EXTENDED_USER_CFG_POINTER != EXT_OFF) &&
                    (cfg_req.dword >= EXTENDED_USER_CFG_POINTER);
      to_user     = user_legacy || user_ext;
      // gap below the extended pointer falls here as well
      above_last  = cfg_req.dword > LAST_IMPLEMENTED_DWORD;
      // full offset, so dwords past the structure do not alias into it
      sn_off      = cfg_req.dword - SN_DW;
      sn_idx      = sn_off[1:0];
      sn_hit      = SERIAL_NUMBER_PRESENT &&
                    (cfg_req.dword >= SN_DW) &&
                    (sn_off <= 10'h002);
   end

   // internal read data; anything unlisted reads zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (sn_hit) begin
         if (sn_idx == 2'h0)
            rd_word = {NEXT_OK, SN_VERSION, SN_ID};
         else if (sn_idx == 2'h1)
            rd_word = SERIAL_NUMBER_VALUE[31:0];
         else
            rd_word = SERIAL_NUMBER_VALUE[63:32];
      end else if (cfg_req.dword == HDR_TYPE_DW) begin
         rd_word = {8'h00, HDR_OK, 16'h0000};
      end else if (cfg_req.dword == ROM_BAR_DW) begin
         rd_word = rom_r;
      end else if (cfg_req.dword == INT_PIN_DW) begin
         rd_word = {16'h0000, PIN_OK, 8'h00};
      end
   end

   always_comb begin
      rsp_nxt = '0;
      rom_nxt = rom_r;
      if (cfg_req.valid) begin
         rsp_nxt.valid   = 1'b1;
         rsp_nxt.to_user = to_user;
         if (!to_user) begin
            rsp_nxt.ur = above_last;
            if (!above_last && !cfg_req.write)
               rsp_nxt.rdata = rd_word;
            if (!above_last && cfg_req.write &&
                cfg_req.dword == ROM_BAR_DW)
               rom_nxt = cfg_req.wdata & ROM_MASK;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cfg_rsp <= '0;
         rom_r   <= ROM_NONE;
      end else begin
         cfg_rsp <= rsp_nxt;
         rom_r   <= rom_nxt;
      end
   end

   // static outputs, loaded once out of reset
   link_cap_s caps_nxt;
   logic [7:0] link_nxt;
   logic       bad_nxt;

   always_comb begin
      caps_nxt.aspm       = ASPM_L0S;
      caps_nxt.l0s_exit   = L0S_EXIT_COMCLK_GEN1;
      caps_nxt.clk_pm     = CLOCK_PM_SUPPORT;
      caps_nxt.dll_active = ROOT_PORT && LINK_ACTIVE_REPORTING;
      link_nxt            = ROOT_PORT ? LINK_NUMBER : 8'h00;
      bad_nxt             = BAD;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         advertised_link_number <= 8'h00;
         link_caps              <= '0;
         rom_bar                <= ROM_NONE;
         legacy_intx_used       <= 1'b0;
         legacy_intx_line       <= 2'h0;
         settings_bad           <= 1'b0;
      end else begin
         advertised_link_number <= link_nxt;
         link_caps              <= caps_nxt;
         rom_bar                <= ROM_MASK;
         legacy_intx_used       <= PIN_OK != 8'h00;
         legacy_intx_line       <= 2'(PIN_OK - 8'h01);
         settings_bad           <= bad_nxt;
      end
   end

   // receive message path
   msg_router u_msg (
      .mclk               (mclk),
      .rst                (rst),
      .message_route_mask (MESSAGE_ROUTE_MASK),
      .rx_digest_trim     (RX_DIGEST_TRIM),
      .rx_in              (rx_in),
      .rx_out             (rx_user),
      .msg_decoded        (msg_decoded),
      .msg_decoded_kind   (msg_decoded_kind)
   );

   // idle inference and recovery entry
   idle_recovery u_idle (
      .mclk                     (mclk),
      .rst                      (rst),
      .idle_mask                (INFERRED_IDLE_MASK),
      .recovery_on_idle_from_l0 (RECOVERY_ON_IDLE_FROM_L0),
      .ltssm                    (ltssm),
      .inferred_idle            (inferred_idle),
      .analog_idle_pin          (analog_idle_pin),
      .eios_seen                (eios_seen),
      .infer_active             (infer_active),
      .enter_recovery           (enter_recovery)
   );
endmodule : cfg_space_decode
`default_nettype wire

// ### sim/cfg_space_decode_props.sv
/*
 assertion checker for the config decode block, ports only.
 assumes a bind from the bench that passes the routing parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_space_decode_props
   import cfg_pkg::*;
#(
   parameter logic [5:0]  LEG_PTR = 6'h3f,
   parameter logic [9:0]  EXT_PTR = 10'h3ff,
   parameter logic [9:0]  LAST_DW = 10'h040,
   parameter logic [10:0] MASK    = 11'h000,
   parameter logic [4:0]  IDLE    = 5'h00,
   parameter logic        TRIM    = 1'b0
) (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               rst,
   // config port
   input  wire cfg_pkg::cfg_req_s  cfg_req,
   input  wire cfg_pkg::cfg_rsp_s  cfg_rsp,
   // receive path
   input  wire cfg_pkg::rx_beat_s  rx_in,
   input  wire cfg_pkg::rx_beat_s  rx_user,
   input  wire logic               msg_decoded,
   input  wire cfg_pkg::msg_kind_e msg_decoded_kind,
   // idle and static
   input  wire cfg_pkg::ltssm_e    ltssm,
   input  wire logic               inferred_idle,
   input  wire logic               infer_active,
   input  wire logic               enter_recovery,
   input  wire cfg_pkg::link_cap_s link_caps,
   input  wire logic [31:0]        rom_bar
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_msg_head;
      rx_in.valid && rx_in.sop && rx_in.is_msg;
   endsequence
   sequence s_td_head;
      TRIM && rx_in.valid && rx_in.sop && rx_in.data[15] ##1 rx_in.valid;
   endsequence
   property p_answer;
      cfg_req.valid |=> cfg_rsp.valid ##1 (cfg_rsp.valid == $past(cfg_req.valid));
   endproperty
   a_answer: assert property (p_answer) else $error("config answer missing");
   property p_legacy;
      cfg_req.valid && cfg_req.dword < 10'h040 && LEG_PTR != 6'h3f
         && cfg_req.dword[5:0] >= LEG_PTR |=> cfg_rsp.to_user && !cfg_rsp.ur;
   endproperty
   a_legacy: assert property (p_legacy) else $error("legacy not routed");
   property p_ext;
      cfg_req.valid && cfg_req.dword >= 10'h040 && EXT_PTR != 10'h3ff
         && cfg_req.dword >= EXT_PTR |=> cfg_rsp.to_user;
   endproperty
   a_ext: assert property (p_ext) else $error("extended not routed");
   property p_gap;
      cfg_req.valid && cfg_req.dword >= 10'h040 && cfg_req.dword > LAST_DW
         && (EXT_PTR == 10'h3ff || cfg_req.dword < EXT_PTR) |=> cfg_rsp.ur && !cfg_rsp.to_user;
   endproperty
   a_gap: assert property (p_gap) else $error("gap not refused");
   property p_user_clean;
      cfg_rsp.valid && cfg_rsp.to_user |-> !cfg_rsp.ur && cfg_rsp.rdata == 32'h0000_0000;
   endproperty
   a_user_clean: assert property (p_user_clean) else $error("routed answer dirty");
   property p_decode;
      s_msg_head |=> msg_decoded && msg_decoded_kind == $past(rx_in.kind);
   endproperty
   a_decode: assert property (p_decode) else $error("message not decoded");
   property p_route;
      s_msg_head ##0 !rx_in.data[15] |=> rx_user.valid == MASK[$past(rx_in.kind)];
   endproperty
   a_route: assert property (p_route) else $error("message routing wrong");
   property p_trim;
      s_td_head |=> rx_user.valid && rx_user.sop && !rx_user.data[15];
   endproperty
   a_trim: assert property (p_trim) else $error("digest bit not cleared");
   property p_recover;
      ltssm == LT_L0 && IDLE[0] && inferred_idle |=> enter_recovery;
   endproperty
   a_recover: assert property (p_recover) else $error("no recovery entry");
   property p_infer;
      ltssm != LT_OTHER |=> infer_active == IDLE[$past(ltssm)];
   endproperty
   a_infer: assert property (p_infer) else $error("inferred idle gating wrong");
   property p_static;
      !$past(rst) && !$past(rst, 2) |-> $stable(rom_bar) && link_caps.aspm == 2'h1;
   endproperty
   a_static: assert property (p_static) else $error("static field moved");
endmodule : cfg_space_decode_props
`default_nettype wire

// ### sim/rx_source.sv
/*
 receive beat source in place of the link partner.
 assumes callers work on falling edges of mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_source
   import cfg_pkg::*;
(
   // clock
   input  wire logic              mclk,
   // beats toward the design
   output var cfg_pkg::rx_beat_s  rx_in
);
   initial rx_in = '0;
   task automatic put(input rx_beat_s b);
      @(negedge mclk);
      rx_in <= b;
   endtask : put
   // idle: stale data flipped so it never passes for a beat
   task automatic rest();
      @(negedge mclk);
      rx_in.valid <= 1'b0;
      rx_in.data  <= ~rx_in.data;
   endtask : rest
endmodule : rx_source
`default_nettype wire

// ### sim/cfg_space_decode_bench.sv
/*
 self-checking bench for the config decode block.
 assumes the package, design and rx_source compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_space_decode_bench;
   import cfg_pkg::*;
   localparam logic [31:0] EXP_ROM = 32'hffff_f801;
   localparam logic [10:0] MASK    = 11'h555;
   localparam logic [4:0]  IDLE    = 5'h05;
   localparam logic [5:0]  LEG_PTR = 6'h30;
   localparam logic [9:0]  EXT_PTR = 10'h060;
   localparam logic [9:0]  LAST_DW = 10'h042;
   localparam logic [7:0]  PIN     = 8'h02;
   localparam logic [2:0]  L0S     = 3'h5;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   cfg_req_s    cfg_req = '0;
   cfg_rsp_s    cfg_rsp;
   rx_beat_s    rx_in;
   rx_beat_s    rx_user;
   logic        decoded, infer_active, enter_recovery, intx_used, bad;
   msg_kind_e   kind;
   ltssm_e      ltssm = LT_OTHER;
   logic        inferred_idle = 1'b0;
   logic        analog_idle = 1'b0;
   logic        eios = 1'b0;
   logic [7:0]  link_num;
   link_cap_s   caps;
   logic [31:0] rom;
   logic [1:0]  intx_line;
   int          fails = 0;
   int          checks_done = 0;
   int          cycles = 0;
   cfg_space_decode #(
      .MESSAGE_ROUTE_MASK(MASK), .RX_DIGEST_TRIM(1'b1), .INFERRED_IDLE_MASK(IDLE),
      .EXPANSION_ROM(EXP_ROM), .LEGACY_USER_CFG_POINTER(LEG_PTR),
      .EXTENDED_USER_CFG_POINTER(EXT_PTR), .INTERRUPT_PIN(PIN),
      .LAST_IMPLEMENTED_DWORD(LAST_DW), .L0S_EXIT_COMCLK_GEN1(L0S), .CLOCK_PM_SUPPORT(1'b1)
   ) i_cfg_space_decode (
      .mclk(mclk), .rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .rx_in(rx_in),
      .rx_user(rx_user), .msg_decoded(decoded), .msg_decoded_kind(kind), .ltssm(ltssm),
      .inferred_idle(inferred_idle), .analog_idle_pin(analog_idle), .eios_seen(eios),
      .infer_active(infer_active), .enter_recovery(enter_recovery),
      .advertised_link_number(link_num), .link_caps(caps), .rom_bar(rom),
      .legacy_intx_used(intx_used), .legacy_intx_line(intx_line), .settings_bad(bad));
   rx_source i_rx_source (.mclk(mclk), .rx_in(rx_in));
   initial begin
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   // caller stands at a falling edge; request left up for back-to-back use
   task automatic cfg(input logic wr, input logic [9:0] dw, input logic usr,
                      input logic ur, input logic [31:0] rd);
      cfg_req = '{1'b1, wr, dw, 32'hffff_ffff};
      @(negedge mclk);
      chk("rsp valid", 1, cfg_rsp.valid);
      chk("to user", usr, cfg_rsp.to_user);
      chk("unsupported", ur, cfg_rsp.ur);
      if (!wr && !ur) chk("read data", rd, cfg_rsp.rdata);
   endtask : cfg
   task automatic t_cfg();
      @(negedge mclk);
      cfg(0, 10'h003, 0, 0, 32'h0000_0000);
      cfg(0, 10'h00f, 0, 0, 32'h0000_0200);
      cfg(0, 10'h040, 0, 0, 32'h0001_0003);
      cfg(0, 10'h041, 0, 0, 32'h0000_0001);
      cfg(1, 10'h040, 0, 0, 32'h0000_0000);
      cfg(0, 10'h040, 0, 0, 32'h0001_0003);
      cfg(1, 10'h00c, 0, 0, 32'h0000_0000);
      cfg(0, 10'h00c, 0, 0, EXP_ROM);
      cfg(0, 10'h02f, 0, 0, 32'h0000_0000);
      cfg(0, 10'h030, 1, 0, 32'h0000_0000);
      cfg(0, LAST_DW, 0, 0, 32'h0000_0000);
      cfg(0, 10'h043, 0, 1, 32'h0000_0000);
      cfg(0, 10'h05f, 0, 1, 32'h0000_0000);
      cfg(0, EXT_PTR, 1, 0, 32'h0000_0000);
      cfg(0, 10'h3ff, 1, 0, 32'h0000_0000);
      cfg_req.valid = 1'b0;
   endtask : t_cfg
   task automatic t_static();
      chk("link number", 8'h00, link_num);
      chk("link caps", {2'h1, L0S, 1'b1, 1'b0}, caps);
      chk("rom setting", EXP_ROM, rom);
      chk("intx used", 1, intx_used);
      chk("intx line", 2'h1, intx_line);
      chk("bad setting", 0, bad);
   endtask : t_static
   task automatic t_msg();
      rx_beat_s b;
      for (int k = 0; k < MSG_KINDS; k++) begin
         b = '{1'b1, 1'b1, 1'b1, 1'b1, msg_kind_e'(k), 32'h0000_0000 + k};
         i_rx_source.put(b);
         i_rx_source.rest();
         chk("decoded", 1, decoded);
         chk("decoded kind", k, kind);
         chk("forwarded", MASK[k], rx_user.valid);
      end
   endtask : t_msg
   task automatic t_trim();
      i_rx_source.put('{1'b1, 1'b1, 1'b0, 1'b0, MSG_ERR_COR, 32'h0000_8abc});
      i_rx_source.put('{1'b1, 1'b0, 1'b0, 1'b0, MSG_ERR_COR, 32'h1234_5678});
      chk("held beat", 0, rx_user.valid);
      i_rx_source.put('{1'b1, 1'b0, 1'b1, 1'b0, MSG_ERR_COR, 32'hdead_beef});
      chk("head data", 32'h0000_0abc, rx_user.data);
      chk("head flags", 3'h6, {rx_user.valid, rx_user.sop, rx_user.eop});
      i_rx_source.rest();
      chk("tail data", 32'h1234_5678, rx_user.data);
      chk("tail flags", 3'h5, {rx_user.valid, rx_user.sop, rx_user.eop});
      i_rx_source.rest();
      chk("digest dropped", 0, rx_user.valid);
   endtask : t_trim
   task automatic t_idle();
      ltssm_e st [5] = '{LT_L0, LT_RCV_CFG, LT_SPEED_OK, LT_SPEED_FAIL, LT_LOOPBACK};
      inferred_idle = 1'b1;
      foreach (st[i]) begin
         ltssm = st[i];
         @(negedge mclk);
         chk("infer active", IDLE[i], infer_active);
         chk("to recovery", i == 0, enter_recovery);
      end
      ltssm = LT_L0;
      inferred_idle = 1'b0;
      analog_idle = 1'b1;
      repeat (4) @(negedge mclk);
      chk("analog ignored", 0, enter_recovery);
      ltssm = LT_OTHER;
   endtask : t_idle
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      t_static();
      t_cfg();
      t_msg();
      t_trim();
      t_idle();
      report_and_stop();
   end
endmodule : cfg_space_decode_bench
bind cfg_space_decode cfg_space_decode_props #(
   .LEG_PTR(LEGACY_USER_CFG_POINTER), .EXT_PTR(EXTENDED_USER_CFG_POINTER),
   .LAST_DW(LAST_IMPLEMENTED_DWORD), .MASK(MESSAGE_ROUTE_MASK),
   .IDLE(INFERRED_IDLE_MASK), .TRIM(RX_DIGEST_TRIM)
) i_cfg_space_decode_props (
   .mclk(mclk), .rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .rx_in(rx_in),
   .rx_user(rx_user), .msg_decoded(msg_decoded), .msg_decoded_kind(msg_decoded_kind),
   .ltssm(ltssm), .inferred_idle(inferred_idle), .infer_active(infer_active),
   .enter_recovery(enter_recovery), .link_caps(link_caps), .rom_bar(rom_bar));
`default_nettype wire
